// ===== logic/mrre_exec.sv
`timescale 1ns/1ps

module mrre_exec (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic instr_valid,
	input wire logic [mrre_pkg::INSTR_W-1:0] instr_word,
	input wire logic [mrre_pkg::PC_W-1:0] stack_top,
	input wire logic [mrre_pkg::ADDR_W-1:0] peek_addr,
	output logic ready,
	output logic stack_pop,
	output logic [mrre_pkg::PC_W-1:0] pc,
	output logic [mrre_pkg::DATA_W-1:0] acc,
	output logic zero_flag,
	output logic carry_flag,
	output logic global_irq_enable,
	output logic [mrre_pkg::DATA_W-1:0] peek_data
);
	import mrre_pkg::*;

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	logic [5:0] opc;
	logic dest;
	logic [ADDR_W-1:0] faddr;
	logic [DATA_W-1:0] lit;
	logic [DATA_W-1:0] file_rd;
	logic [DATA_W-1:0] peek_rd;
	logic [DATA_W-1:0] rot_val;
	logic accept;

	assign opc = instr_word[OPC_MSB:OPC_LSB];
	assign dest = instr_word[DEST_BIT];
	assign faddr = instr_word[ADDR_MSB:0];
	assign lit = instr_word[LIT_MSB:0];

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	mrre_state_type state_q, state_d;
	logic ready_q, ready_d;
	logic pop_q, pop_d;
	logic [PC_W-1:0] pc_q, pc_d;
	logic [DATA_W-1:0] acc_q, acc_d;
	logic zero_q, zero_d;
	logic carry_q, carry_d;
	logic irq_en_q, irq_en_d;
	logic [DATA_W-1:0] peek_q;
	logic wr_en;
	logic [DATA_W-1:0] wr_data;

	// Instructions are taken only while no two-cycle return is pending.
	assign accept = instr_valid && ready_q;
	assign rot_val = {file_rd[CARRY_OUT_BIT-1:0], carry_q};

	always_comb begin
		state_d = state_q;
		ready_d = ready_q;
		pop_d = 1'b0;
		pc_d = pc_q;
		acc_d = acc_q;
		zero_d = zero_q;
		carry_d = carry_q;
		irq_en_d = irq_en_q;
		wr_en = 1'b0;
		wr_data = acc_q;
		case (state_q)
			MRRE_EXEC: begin
				if (accept) begin
					pc_d = pc_q + PC_STEP;
					case (opc)
						COPY_FILE_OP: begin
							zero_d = (file_rd == '0);
							if (dest == DEST_FILE) begin
								wr_en = 1'b1;
								wr_data = file_rd;
							end else begin
								acc_d = file_rd;
							end
						end
						LITERAL_LOAD_OP: begin
							acc_d = lit;
						end
						STORE_ACCUMULATOR_OP: begin
							wr_en = 1'b1;
							wr_data = acc_q;
						end
						ROTATE_LEFT_CARRY_OP: begin
							carry_d = file_rd[CARRY_OUT_BIT];
							if (dest == DEST_FILE) begin
								wr_en = 1'b1;
								wr_data = rot_val;
							end else begin
								acc_d = rot_val;
							end
						end
						RETURN_WITH_LITERAL_OP, SUB_RETURN_OP,
						IRQ_RETURN_OP: begin
							// The popped address lands now; the second
							// cycle is the refill slot with ready low.
							pc_d = stack_top;
							pop_d = 1'b1;
							ready_d = 1'b0;
							state_d = MRRE_SECOND;
							if (opc == RETURN_WITH_LITERAL_OP) begin
								acc_d = lit;
							end
							if (opc == IRQ_RETURN_OP) begin
								irq_en_d = 1'b1;
							end
						end
						default: begin
							// Unknown codes behave as no-operation.
							pc_d = pc_q + PC_STEP;
						end
					endcase
				end
			end
			MRRE_SECOND: begin
				ready_d = 1'b1;
				state_d = MRRE_EXEC;
			end
			default: begin
				ready_d = 1'b1;
				state_d = MRRE_EXEC;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_q <= MRRE_EXEC;
			ready_q <= 1'b1;
			pop_q <= 1'b0;
			pc_q <= PC_RESET;
			acc_q <= ACC_RESET;
			zero_q <= FLAG_RESET;
			carry_q <= FLAG_RESET;
			irq_en_q <= FLAG_RESET;
			peek_q <= ACC_RESET;
		end else begin
			state_q <= state_d;
			ready_q <= ready_d;
			pop_q <= pop_d;
			pc_q <= pc_d;
			acc_q <= acc_d;
			zero_q <= zero_d;
			carry_q <= carry_d;
			irq_en_q <= irq_en_d;
			peek_q <= peek_rd;
		end
	end

	mrre_file_ram u_file (
		.sys_clk(sys_clk),
		.wr_en(wr_en),
		.wr_addr(faddr),
		.wr_data(wr_data),
		.rd_addr(faddr),
		.rd_data(file_rd),
		.peek_addr(peek_addr),
		.peek_data(peek_rd)
	);

	assign ready = ready_q;
	assign stack_pop = pop_q;
	assign pc = pc_q;
	assign acc = acc_q;
	assign zero_flag = zero_q;
	assign carry_flag = carry_q;
	assign global_irq_enable = irq_en_q;
	assign peek_data = peek_q;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	logic is_ret;
	assign is_ret = accept && (opc == SUB_RETURN_OP
		|| opc == IRQ_RETURN_OP || opc == RETURN_WITH_LITERAL_OP);

	copy_to_acc_a: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		accept && opc == COPY_FILE_OP && dest == DEST_ACC
		|=> acc_q == $past(file_rd))
		else $error("copy to accumulator lost value");
	copy_zero_a: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		accept && opc == COPY_FILE_OP
		|=> zero_q == ($past(file_rd) == '0))
		else $error("copy did not update zero flag");
	irq_return_a: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		accept && opc == IRQ_RETURN_OP
		|=> irq_en_q && stack_pop && pc_q == $past(stack_top))
		else $error("interrupt return wrong");
	literal_load_a: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		accept && opc == LITERAL_LOAD_OP
		|=> acc_q == $past(lit) && $stable(zero_q) && $stable(carry_q))
		else $error("literal load wrong");
	ret_literal_a: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		accept && opc == RETURN_WITH_LITERAL_OP
		|=> acc_q == $past(lit) && pc_q == $past(stack_top))
		else $error("return with literal wrong");
	return_two_a: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		is_ret |=> !ready_q && $stable(zero_q) && $stable(carry_q)
		##1 ready_q && !stack_pop)
		else $error("return not two cycles");
	store_acc_a: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		accept && opc == STORE_ACCUMULATOR_OP
		|-> wr_en && wr_data == acc_q && zero_d == zero_q
		&& carry_d == carry_q)
		else $error("store accumulator wrong");
	rotate_left_a: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		accept && opc == ROTATE_LEFT_CARRY_OP && dest == DEST_ACC
		|=> acc_q == {$past(file_rd[6:0]), $past(carry_q)})
		else $error("rotate left wrong");
	rotate_carry_a: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		accept && opc == ROTATE_LEFT_CARRY_OP
		|=> carry_q == $past(file_rd[7]) && $stable(zero_q))
		else $error("rotate carry wrong");
	nop_step_a: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		accept && opc == NOP_OP
		|=> pc_q == $past(pc_q) + PC_STEP && $stable(acc_q)
			&& $stable(carry_q) && $stable(zero_q))
		else $error("no-operation changed state");

	ret_seen_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
		is_ret ##2 accept);
	copy_zero_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
		accept && opc == COPY_FILE_OP && dest == DEST_FILE
		&& file_rd == '0);
	rotate_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
		accept && opc == ROTATE_LEFT_CARRY_OP && carry_q);

endmodule

// ===== logic/mrre_pkg.sv
package mrre_pkg;

	// ------------------------------------------------------------
	// Widths and instruction fields
	// ------------------------------------------------------------
	localparam int DATA_W = 8;
	localparam int ADDR_W = 7;
	localparam int PC_W = 13;
	localparam int INSTR_W = 14;
	localparam int FILE_DEPTH = 128;
	localparam int OPC_MSB = 13;
	localparam int OPC_LSB = 8;
	localparam int DEST_BIT = 7;
	localparam int ADDR_MSB = 6;
	localparam int LIT_MSB = 7;
	localparam int CARRY_IN_BIT = 0;
	localparam int CARRY_OUT_BIT = 7;

	// ------------------------------------------------------------
	// Operation codes in instruction bits 13:8
	// ------------------------------------------------------------
	localparam logic [5:0] NOP_OP = 6'h00;
	localparam logic [5:0] STORE_ACCUMULATOR_OP = 6'h01;
	localparam logic [5:0] SUB_RETURN_OP = 6'h02;
	localparam logic [5:0] IRQ_RETURN_OP = 6'h03;
	localparam logic [5:0] COPY_FILE_OP = 6'h08;
	localparam logic [5:0] ROTATE_LEFT_CARRY_OP = 6'h0d;
	localparam logic [5:0] LITERAL_LOAD_OP = 6'h30;
	localparam logic [5:0] RETURN_WITH_LITERAL_OP = 6'h34;

	// ------------------------------------------------------------
	// Reset values and step
	// ------------------------------------------------------------
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic [12:0] PC_RESET = 13'h0000;
	localparam logic [12:0] PC_STEP = 13'h0001;
	localparam logic FLAG_RESET = 1'b0;
	localparam logic DEST_ACC = 1'b0;
	localparam logic DEST_FILE = 1'b1;

	typedef enum logic {
		MRRE_EXEC,
		MRRE_SECOND
	} mrre_state_type;

endpackage

// ===== logic/mrre_file_ram.sv
`timescale 1ns/1ps

module mrre_file_ram (
	input wire logic sys_clk,
	input wire logic wr_en,
	input wire logic [mrre_pkg::ADDR_W-1:0] wr_addr,
	input wire logic [mrre_pkg::DATA_W-1:0] wr_data,
	input wire logic [mrre_pkg::ADDR_W-1:0] rd_addr,
	output logic [mrre_pkg::DATA_W-1:0] rd_data,
	input wire logic [mrre_pkg::ADDR_W-1:0] peek_addr,
	output logic [mrre_pkg::DATA_W-1:0] peek_data
);
	import mrre_pkg::*;

	// The array has no reset, as a real register file does not.
	logic [DATA_W-1:0] mem [FILE_DEPTH];

	always_ff @(posedge sys_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_comb begin
		rd_data = mem[rd_addr];
		peek_data = mem[peek_addr];
	end

endmodule

// ===== verification/tb_move_return_rotate_exec.sv
`timescale 1ns/1ps

module tb_move_return_rotate_exec;
	import mrre_pkg::*;
	// ------------------------------------------------------------
	// Stimulus, outputs and reference state
	// ------------------------------------------------------------
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic instr_valid = 1'b0;
	logic [13:0] instr_word = 14'h0000;
	logic [12:0] stack_top = 13'h0000;
	logic [6:0] peek_addr = 7'h00;
	logic ready, stack_pop, zero_flag, carry_flag, global_irq_enable;
	logic [12:0] pc;
	logic [7:0] acc, peek_data;
	logic [25:0] st_now;
	logic took = 1'b0;
	logic [25:0] exp_q[$];
	logic [7:0] file_m[128];
	logic [7:0] acc_m = 8'h00;
	logic [12:0] pc_m = 13'h0000;
	logic z_m = 1'b0;
	logic c_m = 1'b0;
	logic irq_en_m = 1'b0;
	logic [5:0] op_t[8] = '{NOP_OP, STORE_ACCUMULATOR_OP, SUB_RETURN_OP,
		IRQ_RETURN_OP, COPY_FILE_OP, ROTATE_LEFT_CARRY_OP, LITERAL_LOAD_OP,
		RETURN_WITH_LITERAL_OP};
	integer seed = 32'h6ffc;
	int n_mismatch = 0;
	int compares = 0;

	assign st_now = {pc, acc, zero_flag, carry_flag, global_irq_enable,
		stack_pop, ready};

	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end

	mrre_exec u_dut (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.instr_valid(instr_valid),
		.instr_word(instr_word),
		.stack_top(stack_top),
		.peek_addr(peek_addr),
		.ready(ready),
		.stack_pop(stack_pop),
		.pc(pc),
		.acc(acc),
		.zero_flag(zero_flag),
		.carry_flag(carry_flag),
		.global_irq_enable(global_irq_enable),
		.peek_data(peek_data)
	);

	// ------------------------------------------------------------
	// Closing and comparison tasks
	// ------------------------------------------------------------
	task automatic end_sim();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk_state(input logic [25:0] e);
		compares++;
		if (st_now !== e) begin
			n_mismatch++;
			$display("unexpected at %0t: state %h want %h", $time, st_now, e);
		end
	endtask

	task automatic chk_val(input logic [7:0] got, input logic [7:0] want);
		compares++;
		if (got !== want) begin
			n_mismatch++;
			$display("unexpected at %0t: file %h want %h", $time, got, want);
		end
	endtask

	// ------------------------------------------------------------
	// Driver with reference model
	// ------------------------------------------------------------
	task automatic drive(input logic v, input logic [13:0] w,
		input logic [12:0] t);
		@(posedge sys_clk);
		instr_valid <= v;
		instr_word <= w;
		stack_top <= t;
	endtask

	task automatic exec(input logic [13:0] w);
		logic [12:0] t;
		logic [7:0] v;
		logic two;
		t = 13'($random(seed));
		v = file_m[w[6:0]];
		two = 1'b0;
		drive(1'b1, w, t);
		pc_m = pc_m + PC_STEP;
		case (w[13:8])
			COPY_FILE_OP: z_m = (v == 8'h00);
			ROTATE_LEFT_CARRY_OP: begin
				v = {v[6:0], c_m};
				c_m = file_m[w[6:0]][7];
			end
			LITERAL_LOAD_OP: acc_m = w[7:0];
			STORE_ACCUMULATOR_OP: file_m[w[6:0]] = acc_m;
			SUB_RETURN_OP, IRQ_RETURN_OP, RETURN_WITH_LITERAL_OP: begin
				two = 1'b1;
				pc_m = t;
				if (w[13:8] == RETURN_WITH_LITERAL_OP) acc_m = w[7:0];
				if (w[13:8] == IRQ_RETURN_OP) irq_en_m = 1'b1;
			end
			default: ;
		endcase
		if (w[13:8] == COPY_FILE_OP || w[13:8] == ROTATE_LEFT_CARRY_OP) begin
			if (w[7]) file_m[w[6:0]] = v;
			else acc_m = v;
		end
		exp_q.push_back({pc_m, acc_m, z_m, c_m, irq_en_m, two, !two});
		// A load offered in the busy cycle must leave no trace.
		if (two) drive(1'b1, {LITERAL_LOAD_OP, 8'($random(seed))}, t);
	endtask

	// ------------------------------------------------------------
	// Monitor and watchdog
	// ------------------------------------------------------------
	always @(posedge sys_clk) begin
		took <= rst_n && instr_valid && ready === 1'b1;
	end

	always @(negedge sys_clk) begin
		if (took) begin
			if (exp_q.size() == 0) begin
				n_mismatch++;
				$display("unexpected at %0t: extra take", $time);
			end else begin
				chk_state(exp_q.pop_front());
			end
		end
	end

	initial begin
		repeat (5000) @(posedge sys_clk);
		n_mismatch++;
		$display("unexpected at %0t: timeout", $time);
		end_sim();
	end

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		int a;
		logic [5:0] op;
		logic [13:0] w;
		logic [6:0] fa;
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(negedge sys_clk);
		chk_state({PC_RESET, ACC_RESET, FLAG_RESET, FLAG_RESET, 3'b001});
		for (a = 0; a < 9; a++) begin
			exec({LITERAL_LOAD_OP, a == 0 ? 8'h00 : 8'($random(seed))});
			exec({STORE_ACCUMULATOR_OP, 1'b1, 7'(a == 8 ? 127 : a)});
		end
		exec({COPY_FILE_OP, 1'b1, 7'h00});
		for (a = 0; a < 60; a++) begin
			op = op_t[$unsigned($random(seed)) % 8];
			w = {op, 8'($random(seed))};
			if (op != LITERAL_LOAD_OP && op != RETURN_WITH_LITERAL_OP) begin
				w[6:0] = 7'($unsigned($random(seed)) % 9);
				if (w[6:0] == 7'h08) w[6:0] = 7'h7f;
			end
			exec(w);
		end
		// A second reset mid-run must clear state but keep the file.
		drive(1'b0, 14'h0000, 13'h0000);
		rst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(negedge sys_clk);
		chk_state({PC_RESET, ACC_RESET, FLAG_RESET, FLAG_RESET, 3'b001});
		pc_m = PC_RESET;
		acc_m = ACC_RESET;
		z_m = FLAG_RESET;
		c_m = FLAG_RESET;
		irq_en_m = FLAG_RESET;
		for (a = 2; a < 8; a++) begin
			if (a == 2 || a == 3 || a == 7) exec({op_t[a], 8'($random(seed))});
		end
		drive(1'b0, 14'h0000, 13'h0000);
		for (a = 0; a < 9; a++) begin
			fa = 7'(a == 8 ? 127 : a);
			@(posedge sys_clk);
			peek_addr <= fa;
			repeat (2) @(posedge sys_clk);
			@(negedge sys_clk);
			chk_val(peek_data, file_m[fa]);
		end
		if (exp_q.size() != 0) begin
			n_mismatch++;
			$display("unexpected at %0t: missing takes", $time);
		end
		end_sim();
	end
endmodule
